// ===== verilog/gpio_ports.sv
// Three interruptable GPIO ports with bit engines behind a Wishbone slave
`timescale 1ns/100ps
//
// Function
// - Three ports at fixed bases, widths 16/16/14.
// - Mode bit hands pin to peripheral; zero is software.
// - Thirteen registers at word indices 0 to 12.
// - Direction one drives, resets to all inputs.
// - Output levels drive only output-direction pins.
// - Level read shows real pin, peripheral pins too.
// - Enabled falling edge sets pending flag.
// - Enabled rising edge sets pending flag.
// - Port request high while any flag set.
// - Writing one clears a flag unless an edge sets it that cycle, zero keeps.
// - Output write forces set-mask bits high unless also clear-masked.
// - Output write forces clear-mask bits low.
// - Map config holds four 4-bit position fields.
// - Engine zero write copies data bit to pin.
// - Engine zero read places pin level at data bit.
// - Engine one works alike with own fields.
module gpio_ports
	import gpio_pkg::*;
(
	input  wire logic                           clk_i,         // Core clock
	input  wire logic                           rst_i,         // Synchronous reset
	input  wire logic [gpio_pkg::ADR_W-1:0]     adr_i,         // Byte address
	input  wire logic [gpio_pkg::DAT_W-1:0]     dat_i,         // Write data
	output logic      [gpio_pkg::DAT_W-1:0]     dat_o,         // Read data
	input  wire logic                           we_i,          // Write enable
	input  wire logic [3:0]                     sel_i,         // Byte selects
	input  wire logic                           stb_i,         // Strobe
	input  wire logic                           cyc_i,         // Cycle
	output logic                                ack_o,         // Acknowledge
	input  wire gpio_pkg::port_vec_t            pin_in_i,      // Pin levels
	output gpio_pkg::port_vec_t                 pin_out_o,     // Pin drive level
	output gpio_pkg::port_vec_t                 pin_oe_o,      // Pin drive enable
	input  wire gpio_pkg::port_vec_t            periph_out_i,  // Peripheral level
	input  wire gpio_pkg::port_vec_t            periph_oe_i,   // Peripheral enable
	output gpio_pkg::port_vec_t                 periph_sel_o,  // Pin given away
	output logic      [gpio_pkg::NUM_PORTS-1:0] port_irq_o,    // Per port request
	output logic                                irq_o          // Masked request
);
	import gpio_pkg::*;

	// Byte lane merge of a 16-bit register
	function automatic logic [15:0] merge(
		input logic [15:0] old,
		input logic [15:0] data,
		input logic [15:0] mask
	);
		merge = (old & ~mask) | (data & mask);
	endfunction

	// Bus slave state
	bus_state_e             state;      // Slave phase
	bus_state_e             next_state; // Next phase
	logic                   ack;        // Acknowledge flop
	logic                   next_ack;   // Next acknowledge
	logic [DAT_W-1:0]       dat;        // Read data flop
	logic [DAT_W-1:0]       next_dat;   // Next read data
	logic                   irq;        // Masked request flop
	logic                   next_irq;   // Next masked request

	// Decoded request
	logic [15:0]            word;       // Word address
	logic [OFS_W-1:0]       ofs;        // Register index in port
	logic [NUM_PORTS-1:0]   hit_port;   // Port addressed
	logic [15:0]            wmask;      // Byte selects as bit mask
	logic [15:0]            wdat;       // Low half of write data
	logic                   wr_go;      // Write takes effect now
	logic [15:0]            rd_val;     // Selected read value

	// Per port collections
	port_vec_t              synced;     // Synchronised pins
	port_vec_t              pending;    // Pending flags
	port_vec_t              rd_all;     // Read value of each port
	port_vec_t              irq_src;    // Unmasked pending flags
	logic [NUM_PORTS-1:0]   port_any;   // Request of each port

	// Every pin passes two flops before edge logic or reads
	pin_sync #(
		.W (NUM_PORTS * PORT_W)
	) u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i (pin_in_i),
		.sync_o  (synced)
	);

	// Address decode; a port owns 32 words from its base
	always_comb
	begin
		word   = adr_i[ADR_W-1:2];
		ofs    = word[OFS_W-1:0];
		wmask  = {{8{sel_i[1]}}, {8{sel_i[0]}}};
		wdat   = dat_i[15:0];
		for (int p = 0; p < NUM_PORTS; p++)
		begin
			hit_port[p] = (word[15:OFS_W] == PORT_BASE[p][15:OFS_W]);
		end
	end

	// Writes land at the edge where the master samples ack
	always_comb
	begin
		wr_go = (state == BUS_ACK) && cyc_i && stb_i && we_i;
	end

	// One port each: registers, pending logic, pin drive
	for (genvar p = 0; p < NUM_PORTS; p++)
	begin : g_port
		port_cfg_s   cfg;       // Software state
		port_cfg_s   next_cfg;  // Next software state
		pin_drive_s  drv;       // Pin drive flops
		pin_drive_s  next_drv;  // Next pin drive
		logic [15:0] lv;        // Present pin levels
		logic [15:0] clr;       // Write-one clear of flags
		logic [15:0] rd;        // Read value of this port
		logic [3:0]  pin0;      // Engine zero pin
		logic [3:0]  dat0;      // Engine zero data bit
		logic [3:0]  pin1;      // Engine one pin
		logic [3:0]  dat1;      // Engine one data bit

		// Missing pins of the narrow port read low
		always_comb
		begin
			lv   = synced[p] & PORT_MASK[p];
			pin0 = cfg.map_cfg[ENG0_PIN_LSB +: FIELD_W];
			dat0 = cfg.map_cfg[ENG0_DAT_LSB +: FIELD_W];
			pin1 = cfg.map_cfg[ENG1_PIN_LSB +: FIELD_W];
			dat1 = cfg.map_cfg[ENG1_DAT_LSB +: FIELD_W];
		end

		// Register writes; bits beyond the port width never set, except in map_cfg
		always_comb
		begin
			next_cfg = cfg;
			clr      = 16'h0000;
			if (wr_go && hit_port[p])
			begin
				case (ofs)
					OFS_DIR:
					begin
						next_cfg.dir = merge(cfg.dir, wdat, wmask) & PORT_MASK[p];
					end
					OFS_OUT:
					begin
						// Clear mask is applied last, so it wins a conflict
						next_cfg.out_lv = ((merge(cfg.out_lv, wdat, wmask) | cfg.hi_mask)
							& ~cfg.clr_mask) & PORT_MASK[p];
					end
					OFS_FALL:
					begin
						next_cfg.fall_en = merge(cfg.fall_en, wdat, wmask) & PORT_MASK[p];
					end
					OFS_RISE:
					begin
						next_cfg.rise_en = merge(cfg.rise_en, wdat, wmask) & PORT_MASK[p];
					end
					OFS_PEND:
					begin
						clr = wdat & wmask;
					end
					OFS_SET:
					begin
						next_cfg.hi_mask = merge(cfg.hi_mask, wdat, wmask) & PORT_MASK[p];
					end
					OFS_CLR:
					begin
						next_cfg.clr_mask = merge(cfg.clr_mask, wdat, wmask) & PORT_MASK[p];
					end
					OFS_MAP:
					begin
						next_cfg.map_cfg = merge(cfg.map_cfg, wdat, wmask);
					end
					OFS_ENG0:
					begin
						// Only acts when the lane carrying the data bit is selected
						if (wmask[dat0])
						begin
							next_cfg.out_lv[pin0] = wdat[dat0] & PORT_MASK[p][pin0];
						end
					end
					OFS_ENG1:
					begin
						if (wmask[dat1])
						begin
							next_cfg.out_lv[pin1] = wdat[dat1] & PORT_MASK[p][pin1];
						end
					end
					OFS_PERIPH:
					begin
						next_cfg.periph_sel = merge(cfg.periph_sel, wdat, wmask)
							& PORT_MASK[p];
					end
					OFS_IRQ_MASK:
					begin
						next_cfg.irq_mask = merge(cfg.irq_mask, wdat, wmask) & PORT_MASK[p];
					end
					default:
					begin
						// Level register and holes ignore writes
					end
				endcase
			end
		end

		// Pin drive: peripheral owns a pin whose mode bit is set
		always_comb
		begin
			for (int b = 0; b < PORT_W; b++)
			begin
				if (cfg.periph_sel[b])
				begin
					next_drv.level[b] = periph_out_i[p][b] & PORT_MASK[p][b];
					next_drv.oe[b]    = periph_oe_i[p][b] & PORT_MASK[p][b];
				end
				else
				begin
					next_drv.level[b] = cfg.out_lv[b] & cfg.dir[b];
					next_drv.oe[b]    = cfg.dir[b];
				end
			end
		end

		// Read view of this port; force masks read back as zero
		always_comb
		begin
			rd = 16'h0000;
			case (ofs)
				OFS_DIR:      rd = cfg.dir;
				OFS_OUT:      rd = cfg.out_lv;
				OFS_LEVELS:   rd = lv;
				OFS_FALL:     rd = cfg.fall_en;
				OFS_RISE:     rd = cfg.rise_en;
				OFS_PEND:     rd = pending[p];
				OFS_MAP:      rd = cfg.map_cfg;
				OFS_ENG0:     rd[dat0] = lv[pin0];
				OFS_ENG1:     rd[dat1] = lv[pin1];
				OFS_PERIPH:   rd = cfg.periph_sel;
				OFS_IRQ_MASK: rd = cfg.irq_mask;
				default:      rd = 16'h0000;
			endcase
		end

		// Sticky flags and the port request
		edge_pending #(
			.W (PORT_W)
		) u_pend (
			.clk_i     (clk_i),
			.rst_i     (rst_i),
			.level_i   (lv),
			.fall_en_i (cfg.fall_en),
			.rise_en_i (cfg.rise_en),
			.clear_i   (clr),
			.pending_o (pending[p]),
			.any_o     (port_any[p])
		);

		assign rd_all[p]  = rd;
		assign irq_src[p] = pending[p] & cfg.irq_mask;

		// Registers only
		always_ff @(posedge clk_i)
		begin
			if (rst_i)
			begin
				cfg <= '{default: REG_RESET};
				drv <= '{default: REG_RESET};
			end
			else
			begin
				cfg <= next_cfg;
				drv <= next_drv;
			end
		end

		assign pin_out_o[p]    = drv.level;
		assign pin_oe_o[p]     = drv.oe;
		assign periph_sel_o[p] = cfg.periph_sel;
	end

	// Read mux over ports; unmapped words read zero
	always_comb
	begin
		rd_val = 16'h0000;
		for (int p = 0; p < NUM_PORTS; p++)
		begin
			if (hit_port[p])
			begin
				rd_val = rd_all[p];
			end
		end
	end

	// Classic single cycle slave: one wait state, then ack for one cycle
	always_comb
	begin
		next_state = state;
		next_ack   = 1'b0;
		next_dat   = dat;
		case (state)
			BUS_IDLE:
			begin
				if (cyc_i && stb_i)
				begin
					// Read data is captured together with ack
					next_state = BUS_ACK;
					next_ack   = 1'b1;
					next_dat   = {16'h0000, rd_val};
				end
			end
			BUS_ACK:
			begin
				// Master releases after the ack edge; no back to back ack
				next_state = BUS_IDLE;
			end
			default:
			begin
				next_state = BUS_IDLE;
			end
		endcase
	end

	// Combined request: unmasked flags of any port
	always_comb
	begin
		next_irq = |irq_src;
	end

	// Registers only
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state <= BUS_IDLE;
			ack   <= 1'b0;
			dat   <= DAT_RESET;
			irq   <= 1'b0;
		end
		else
		begin
			state <= next_state;
			ack   <= next_ack;
			dat   <= next_dat;
			irq   <= next_irq;
		end
	end

	assign ack_o      = ack;
	assign dat_o      = dat;
	assign irq_o      = irq;
	assign port_irq_o = port_any;
endmodule

// ===== shared/gpio_pkg.sv
// Register map, reset values and carrier types shared by the GPIO port block
package gpio_pkg;

	// Structure of the block
	localparam int NUM_PORTS = 3;  // Number of port instances
	localparam int PORT_W    = 16; // Widest port
	localparam int DAT_W     = 32; // Wishbone data width
	localparam int ADR_W     = 18; // Wishbone byte address width
	localparam int OFS_W     = 5;  // Register index width inside a port
	localparam int FIELD_W   = 4;  // Width of a bit engine field

	// Word base of each port; byte address is four times the word address
	localparam logic [NUM_PORTS-1:0][15:0] PORT_BASE = {16'hFCE0, 16'hFCC0, 16'hFCA0};
	// Pins that exist in each port
	localparam logic [NUM_PORTS-1:0][15:0] PORT_MASK = {16'h3FFF, 16'hFFFF, 16'hFFFF};

	// Register indices inside a port
	localparam logic [OFS_W-1:0] OFS_DIR      = 5'h00;
	localparam logic [OFS_W-1:0] OFS_OUT      = 5'h01;
	localparam logic [OFS_W-1:0] OFS_LEVELS   = 5'h02;
	localparam logic [OFS_W-1:0] OFS_FALL     = 5'h03;
	localparam logic [OFS_W-1:0] OFS_RISE     = 5'h04;
	localparam logic [OFS_W-1:0] OFS_PEND     = 5'h05;
	localparam logic [OFS_W-1:0] OFS_SET      = 5'h06;
	localparam logic [OFS_W-1:0] OFS_CLR      = 5'h07;
	localparam logic [OFS_W-1:0] OFS_MAP      = 5'h08;
	localparam logic [OFS_W-1:0] OFS_ENG0     = 5'h09;
	localparam logic [OFS_W-1:0] OFS_ENG1     = 5'h0a;
	localparam logic [OFS_W-1:0] OFS_PERIPH   = 5'h0b;
	localparam logic [OFS_W-1:0] OFS_IRQ_MASK = 5'h0c;

	// Reset values
	localparam logic [15:0]      REG_RESET = 16'h0000;
	localparam logic [DAT_W-1:0] DAT_RESET = 32'h0000_0000;

	// Field positions of single_pin_map_config
	localparam int ENG0_PIN_LSB = 0;
	localparam int ENG0_DAT_LSB = 4;
	localparam int ENG1_PIN_LSB = 8;
	localparam int ENG1_DAT_LSB = 12;

	// Bus slave states
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} bus_state_e;

	// Software-written state of one port
	typedef struct packed {
		logic [15:0] dir;        // pin_direction
		logic [15:0] out_lv;     // output_levels
		logic [15:0] fall_en;    // falling_edge_irq_enable
		logic [15:0] rise_en;    // rising_edge_irq_enable
		logic [15:0] hi_mask;    // force_high_mask
		logic [15:0] clr_mask;   // force_low_mask
		logic [15:0] map_cfg;    // single_pin_map_config
		logic [15:0] periph_sel; // peripheral_select
		logic [15:0] irq_mask;   // Interrupt mask of edge_pending_flags
	} port_cfg_s;

	// Pin drive of one port
	typedef struct packed {
		logic [15:0] level; // Level driven
		logic [15:0] oe;    // Output enable
	} pin_drive_s;

	typedef logic [NUM_PORTS-1:0][PORT_W-1:0] port_vec_t;

endpackage

// ===== verilog/pin_sync.sv
// Two-flop synchroniser for the GPIO pin inputs
`timescale 1ns/100ps
module pin_sync #(
	parameter int W = 48
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] stage1; // Metastable stage, read only by stage two
	logic [W-1:0] stage2; // Settled level

	// First stage feeds only the second stage
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			stage1 <= '0;
			stage2 <= '0;
		end
		else
		begin
			stage1 <= async_i;
			stage2 <= stage1;
		end
	end

	assign sync_o = stage2;
endmodule

// ===== verilog/edge_pending.sv
// Edge detection and sticky pending flags of one GPIO port
`timescale 1ns/100ps
module edge_pending #(
	parameter int W = 16
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] level_i,   // Synchronised pin levels
	input  wire logic [W-1:0] fall_en_i, // Falling edge enables
	input  wire logic [W-1:0] rise_en_i, // Rising edge enables
	input  wire logic [W-1:0] clear_i,   // Write-one clear, one cycle
	output logic      [W-1:0] pending_o, // Sticky pending flags
	output logic              any_o      // Some flag set
);
	logic [W-1:0] prev;         // Level one cycle ago
	logic [W-1:0] pending;      // Pending flags
	logic [W-1:0] next_pending; // Next pending flags
	logic         any;          // Registered OR of flags
	logic         next_any;     // Next OR of flags

	// Per bit: an enabled edge sets, a clear only acts without an edge
	for (genvar b = 0; b < W; b++)
	begin : g_bit
		assign next_pending[b] = (fall_en_i[b] & prev[b] & ~level_i[b])
			| (rise_en_i[b] & ~prev[b] & level_i[b])
			| (pending[b] & ~clear_i[b]);
	end

	// Request follows the flags, so it stays until all are cleared
	always_comb
	begin
		next_any = |next_pending;
	end

	// Registers only
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			prev    <= '0;
			pending <= '0;
			any     <= 1'b0;
		end
		else
		begin
			prev    <= level_i;
			pending <= next_pending;
			any     <= next_any;
		end
	end

	assign pending_o = pending;
	assign any_o     = any;
endmodule

// ===== sim/gpio_ports_assertions.sv
// Port-level checks of the GPIO port block, bound to its top module
`timescale 1ns/100ps
module gpio_ports_assertions
	import gpio_pkg::*;
(
	input wire logic                           clk_i,
	input wire logic                           rst_i,
	input wire logic [gpio_pkg::ADR_W-1:0]     adr_i,
	input wire logic [gpio_pkg::DAT_W-1:0]     dat_i,
	input wire logic [gpio_pkg::DAT_W-1:0]     dat_o,
	input wire logic                           we_i,
	input wire logic [3:0]                     sel_i,
	input wire logic                           stb_i,
	input wire logic                           cyc_i,
	input wire logic                           ack_o,
	input wire gpio_pkg::port_vec_t            pin_in_i,
	input wire gpio_pkg::port_vec_t            pin_out_o,
	input wire gpio_pkg::port_vec_t            pin_oe_o,
	input wire gpio_pkg::port_vec_t            periph_out_i,
	input wire gpio_pkg::port_vec_t            periph_oe_i,
	input wire gpio_pkg::port_vec_t            periph_sel_o,
	input wire logic [gpio_pkg::NUM_PORTS-1:0] port_irq_o,
	input wire logic                           irq_o
);
	// Word address of the port 1 pending flags, the port the bench raises
	localparam logic [15:0] PEND1 = PORT_BASE[1] + 16'(OFS_PEND);

	// One clock domain, so one default clock and reset
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// A fresh request is answered exactly one cycle later
	ack_latency_a: assert property (cyc_i && stb_i && !ack_o && !$past(ack_o) |=> ack_o)
		else $error("bus request not acknowledged after one cycle");
	// Acknowledge is a single pulse
	ack_pulse_a: assert property (ack_o |=> !ack_o)
		else $error("acknowledge held longer than one cycle");
	// Registers are sixteen bits, the upper read half stays zero
	upper_zero_a: assert property (dat_o[31:16] == 16'h0000)
		else $error("upper read data not zero");
	// A software-mode pin that is not an output is never driven high
	input_undriven_a: assert property (
		(pin_out_o & ~pin_oe_o & ~(periph_sel_o | $past(periph_sel_o))) == '0)
		else $error("level driven on undriven pin");
	// Selected pins follow the peripheral one cycle late
	periph_path_a: assert property ((((pin_oe_o ^ $past(periph_oe_i))
		| ((pin_out_o ^ $past(periph_out_i)) & $past(periph_oe_i)))
		& periph_sel_o & $past(periph_sel_o)) == '0)
		else $error("peripheral pin not following peripheral");
	// Port request drops only after a flag-clearing write
	pend_clear_a: assert property ($fell(port_irq_o[1]) |->
		$past(ack_o && we_i && adr_i[17:2] == PEND1))
		else $error("port request dropped without clear");
	// Masked request needs a pending port one cycle earlier
	irq_source_a: assert property (irq_o |-> $past(|port_irq_o))
		else $error("request without pending flag");
	// A new request follows a pin change through two sync flops
	edge_source_a: assert property ($rose(port_irq_o[1]) |->
		$past(pin_in_i[1], 3) != $past(pin_in_i[1], 4))
		else $error("request without pin edge");
	// Leaving reset, no pin is driven, irq_o is low and no ack is given
	reset_idle_a: assert property ($fell(rst_i) |-> pin_oe_o == '0 && !irq_o && !ack_o)
		else $error("outputs not idle after reset");

	// Main scenarios reached
	cover property (ack_o && we_i);
	cover property ($rose(port_irq_o[1]));
	cover property ($rose(irq_o));
endmodule

bind gpio_ports gpio_ports_assertions gpio_ports_assertions_i (
	.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
	.we_i(we_i), .sel_i(sel_i), .stb_i(stb_i), .cyc_i(cyc_i), .ack_o(ack_o),
	.pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
	.periph_out_i(periph_out_i), .periph_oe_i(periph_oe_i),
	.periph_sel_o(periph_sel_o), .port_irq_o(port_irq_o), .irq_o(irq_o)
);

// ===== sim/pin_world.sv
// External devices on the GPIO pins
`timescale 1ns/100ps
module pin_world
	import gpio_pkg::*;
(
	input  wire gpio_pkg::port_vec_t drive_level_i, // Block drive level
	input  wire gpio_pkg::port_vec_t drive_en_i,    // Block drive enable
	input  wire gpio_pkg::port_vec_t ext_level_i,   // Level the devices drive
	output gpio_pkg::port_vec_t      pin_level_o    // Resolved wire level
);
	// Devices hold every pin the block leaves alone, so no pin floats
	assign pin_level_o = (drive_level_i & drive_en_i) | (ext_level_i & ~drive_en_i);
endmodule

// ===== sim/gpio_ports_with_bit_engines_bench.sv
// Self-checking bench of the GPIO port block
`timescale 1ns/100ps
module gpio_ports_with_bit_engines_bench;
	import gpio_pkg::*;

	// Write-then-read row
	typedef struct packed {
		logic [1:0]  p;
		logic [4:0]  o;
		logic [15:0] w;
		logic [15:0] r;
	} row_s;

	logic                  clk_i = 1'b0;
	logic                  rst_i = 1'b1;
	logic [ADR_W-1:0]      adr_i = '0;
	logic [DAT_W-1:0]      dat_i = DAT_RESET;
	logic                  we_i = 1'b0;
	logic [3:0]            sel_i = 4'h0;
	logic                  stb_i = 1'b0;
	logic                  cyc_i = 1'b0;
	port_vec_t             periph_out_i = '0;
	port_vec_t             periph_oe_i = '0;
	port_vec_t             ext_level = '0;  // Devices start low so levels read 0
	port_vec_t             pin_in_i;
	port_vec_t             pin_out_o;
	port_vec_t             pin_oe_o;
	port_vec_t             periph_sel_o;
	logic [DAT_W-1:0]      dat_o;
	logic                  ack_o;
	logic [NUM_PORTS-1:0]  port_irq_o;
	logic                  irq_o;
	int                    mismatches = 0;
	int                    samples_checked = 0;
	int                    cycles = 0;
	logic [31:0]           q;
	// Ordinary cases: read-only, port 2 width, plain and write-only registers
	row_s rows[6] = '{'{2'd0, OFS_LEVELS, 16'hFFFF, 16'h0000},
		'{2'd2, OFS_DIR, 16'hFFFF, 16'h3FFF}, '{2'd1, OFS_FALL, 16'h1234, 16'h1234},
		'{2'd0, OFS_SET, 16'hFFFF, 16'h0000}, '{2'd0, OFS_MAP, 16'h4321, 16'h4321},
		'{2'd2, OFS_IRQ_MASK, 16'hFFFF, 16'h3FFF}};

	gpio_ports gpio_ports_i (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i),
		.dat_o(dat_o), .we_i(we_i), .sel_i(sel_i), .stb_i(stb_i), .cyc_i(cyc_i),
		.ack_o(ack_o), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
		.periph_out_i(periph_out_i), .periph_oe_i(periph_oe_i),
		.periph_sel_o(periph_sel_o), .port_irq_o(port_irq_o), .irq_o(irq_o));
	pin_world pin_world_i (.drive_level_i(pin_out_o), .drive_en_i(pin_oe_o),
		.ext_level_i(ext_level), .pin_level_o(pin_in_i));

	// 100 MHz clock
	initial
	begin
		forever #5 clk_i = ~clk_i;
	end

	// Hang guard: the run needs well under this many cycles
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			mismatches++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Classic cycle; ack is read before this edge's updates land
	task automatic bus(input logic w, input int p, input logic [4:0] o, input logic [15:0] d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= {PORT_BASE[p] + 16'(o), 2'b00};
		dat_i <= {16'h0000, d};
		sel_i <= 4'hF;
		@(posedge clk_i);
		while (ack_o !== 1'b1)
			@(posedge clk_i);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask

	task automatic wr(input int p, input logic [4:0] o, input logic [15:0] d);
		bus(1'b1, p, o, d);
	endtask

	task automatic rd(input int p, input logic [4:0] o, input logic [15:0] exp);
		bus(1'b0, p, o, 16'h0000);
		chk(q, {16'h0000, exp});
	endtask

	initial
	begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		// Reset values of registers 0 to 10 of every port
		for (int p = 0; p < 3; p++)
			for (int o = 0; o < 11; o++)
				rd(p, 5'(o), 16'h0000);
		rd(0, 5'h0d, 16'h0000); // (unmapped index reads zero)
		foreach (rows[i])
		begin
			wr(rows[i].p, rows[i].o, rows[i].w);
			rd(rows[i].p, rows[i].o, rows[i].r);
		end
		// Low byte as outputs; only those pins are driven
		wr(0, OFS_DIR, 16'h00FF);
		wr(0, OFS_SET, 16'h0000);
		wr(0, OFS_OUT, 16'h0F0F);
		repeat (4) @(posedge clk_i);
		chk(32'(pin_oe_o[0]), 32'h0000_00FF);
		chk(32'(pin_out_o[0]), 32'h0000_000F);
		rd(0, OFS_LEVELS, 16'h000F);
		// Masks apply on an output write
		wr(0, OFS_SET, 16'hF000);
		wr(0, OFS_CLR, 16'h000F);
		wr(0, OFS_OUT, 16'h0330);
		rd(0, OFS_OUT, 16'hF330);
		// Engine 0: pin 1 from data bit 9; engine 1: pin 4 from data bit 12
		wr(0, OFS_MAP, 16'hC491);
		wr(0, OFS_ENG0, 16'h0200);
		wr(0, OFS_ENG1, 16'h0000);
		rd(0, OFS_OUT, 16'hF322);
		rd(0, OFS_ENG0, 16'h0200);
		rd(0, OFS_ENG1, 16'h0000);
		// Edges on input pins of port 1
		wr(1, OFS_RISE, 16'h0001);
		wr(1, OFS_FALL, 16'h0002);
		wr(1, OFS_IRQ_MASK, 16'h0001);
		ext_level[1][0] <= 1'b1;
		repeat (5) @(posedge clk_i);
		chk(32'(port_irq_o[1]), 32'h0000_0001);
		chk(32'(irq_o), 32'h0000_0001);
		ext_level[1][1] <= 1'b1;
		repeat (5) @(posedge clk_i);
		ext_level[1][1] <= 1'b0;
		repeat (5) @(posedge clk_i);
		rd(1, OFS_PEND, 16'h0003);
		wr(1, OFS_PEND, 16'h0001);
		rd(1, OFS_PEND, 16'h0002);
		chk(32'(port_irq_o[1]), 32'h0000_0001);
		chk(32'(irq_o), 32'h0000_0000);
		wr(1, OFS_PEND, 16'h0002);
		rd(1, OFS_PEND, 16'h0000);
		chk(32'(port_irq_o[1]), 32'h0000_0000);
		// Falling edge of pin 1 reaches the flags at the clearing write's ack edge
		ext_level[1][1] <= 1'b1;
		repeat (5) @(posedge clk_i);
		ext_level[1][1] <= 1'b0;
		wr(1, OFS_PEND, 16'h0002);
		rd(1, OFS_PEND, 16'h0002);
		wr(1, OFS_PEND, 16'h0002);
		rd(1, OFS_PEND, 16'h0000);
		// Pin 0 of port 2 handed to a peripheral
		periph_out_i[2] <= 16'hFFFF;
		periph_oe_i[2] <= 16'h0001;
		wr(2, OFS_PERIPH, 16'h0001);
		repeat (4) @(posedge clk_i);
		chk(32'(pin_oe_o[2]), 32'h0000_3FFF);
		chk(32'(pin_out_o[2]), 32'h0000_0001);
		chk(32'(periph_sel_o[2]), 32'h0000_0001);
		rd(2, OFS_LEVELS, 16'h0001);
		// Second reset in mid-run
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(0, OFS_DIR, 16'h0000);
		print_verdict();
	end
endmodule
